//--- dv/can_engine_model.sv
/* Protocol engine stand-in: state levels, error counters, channel pulses.
   Assumes the bench calls its tasks on sys_clk. */
`timescale 1ns/100ps
`default_nettype none
module can_engine_model (
  input  wire logic   sys_clk,
  output logic [4:0]  lvl,
  output logic [7:0]  rxErr,
  output logic [7:0]  txErr,
  output logic [31:0] irqSet
);
  initial begin
    lvl = 5'h00;
    rxErr = 8'h00;
    txErr = 8'h00;
    irqSet = 32'h0;
  end
  task automatic setLvl(input logic [4:0] l, input logic [7:0] r, input logic [7:0] t);
    @(posedge sys_clk);
    lvl <= l;
    rxErr <= r;
    txErr <= t;
  endtask
  // Channel events are single-cycle pulses.
  task automatic pulse(input logic [31:0] m);
    @(posedge sys_clk);
    irqSet <= m;
    @(posedge sys_clk);
    irqSet <= 32'h0;
  endtask
endmodule
`default_nettype wire

//--- dv/can_status_interrupt_regs_properties.sv
/* Port checks of the CAN status and interrupt block.
   Assumes it is bound into can_status_interrupt_regs. */
`timescale 1ns/100ps
`default_nettype none
`include "can_status_cfg.svh"
module can_status_interrupt_regs_properties #(
  parameter int CHANNELS = 32
) (
  input wire logic                sys_clk,
  input wire logic                rstn,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic [7:0]          wb_adr_i,
  input wire logic [31:0]         wb_dat_o,
  input wire logic                wb_ack_o,
  input wire logic                ctrlEnabled,
  input wire logic                abortReq,
  input wire logic [7:0]          rxErrCount,
  input wire logic [7:0]          txErrCount,
  input wire logic [CHANNELS-1:0] channelIrqSet,
  input wire logic                channelWrReq,
  input wire logic                channelWrAllow,
  input wire logic [CHANNELS-1:0] channelIrqPending,
  input wire logic                initInProgress,
  input wire logic                irq
);
  localparam int INIT = 8 * CHANNELS;
  logic [15:0] initCnt_q;
  // Counts cycles since reset release, saturating just past the init span.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      initCnt_q <= 16'h0000;
    end else if (initCnt_q <= 16'(INIT)) begin
      initCnt_q <= initCnt_q + 16'h0001;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ackOnce; wb_ack_o ##1 !wb_ack_o; endsequence
  sequence s_statusRd; wb_ack_o && !wb_we_i && wb_adr_i == `OFS_CTRL_STATUS; endsequence
  property p_ack; s_req |=> s_ackOnce; endproperty
  property p_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  property p_wrAllow; channelWrAllow == (channelWrReq && !initInProgress); endproperty
  property p_init;
    (initCnt_q < 16'(INIT) && initInProgress) || initCnt_q == 16'(INIT)
      || (initCnt_q > 16'(INIT) && !initInProgress);
  endproperty
  property p_set;
    |channelIrqSet |=> (channelIrqPending & $past(channelIrqSet)) == $past(channelIrqSet);
  endproperty
  property p_clr;
    |($past(channelIrqPending) & ~channelIrqPending)
      |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
                && wb_adr_i == `OFS_CHANNEL_IRQ_CLEAR);
  endproperty
  property p_irq; |channelIrqPending |-> irq; endproperty
  property p_rd;
    s_statusRd |-> wb_dat_o[31:8] == {$past(txErrCount), $past(rxErrCount), 8'h00}
      && {wb_dat_o[7], wb_dat_o[5], wb_dat_o[1:0]} == {$past(|channelIrqPending),
      $past(abortReq), $past(initInProgress), $past(ctrlEnabled)};
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing");
  a_idle: assert property (p_idle) else $error("data outside ack");
  a_wrAllow: assert property (p_wrAllow) else $error("channel write gate");
  a_init: assert property (p_init) else $error("init span");
  a_set: assert property (p_set) else $error("channel flag not set");
  a_clr: assert property (p_clr) else $error("channel flag lost");
  a_irq: assert property (p_irq) else $error("channel irq missing");
  a_rd: assert property (p_rd) else $error("status read");
endmodule
bind can_status_interrupt_regs can_status_interrupt_regs_properties #(.CHANNELS(CHANNELS))
  propsChk (.sys_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
  .wb_ack_o, .ctrlEnabled, .abortReq, .rxErrCount, .txErrCount, .channelIrqSet,
  .channelWrReq, .channelWrAllow, .channelIrqPending, .initInProgress, .irq);
`default_nettype wire

//--- dv/can_status_interrupt_regs_test.sv
/* Self-checking bench of the CAN status and interrupt block.
   Assumes the engine model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
`include "can_status_cfg.svh"
module can_status_interrupt_regs_test;
  logic        sys_clk;
  logic        rstn = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        ctrlEnabled, errPassive, bus_off_flag, abortReq, overloadReq;
  logic [7:0]  rxErrCount, txErrCount;
  logic [31:0] channelIrqSet, channelActive, channelIrqPending;
  logic [31:0] channelEnable = 32'h0;
  logic        channelWrReq = 1'b0;
  logic        channelWrAllow, initInProgress, irq;
  logic [31:0] q;
  int          numErrors = 0;
  int          nChecks = 0;
  can_status_interrupt_regs dut (.*);
  can_engine_model eng (.sys_clk(sys_clk), .rxErr(rxErrCount), .txErr(txErrCount),
    .lvl({overloadReq, abortReq, bus_off_flag, errPassive, ctrlEnabled}), .irqSet(channelIrqSet));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    #20000;
    numErrors++;
    wrapUp();
  end
  task automatic wrapUp();
    if (numErrors == 0 && nChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    nChecks++;
    if (g !== e) begin
      numErrors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic irqIs(input logic e);
    @(posedge sys_clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  task automatic tInit();
    channelWrReq <= 1'b1;
    bus(1'b0, `OFS_CTRL_STATUS, 32'h0);
    chk("init", 32'h2, q & 32'h6);
    chk("wrAllow", 32'h0, {31'h0, channelWrAllow});
    bus(1'b0, `OFS_IRQ_MASK, 32'h0);
    chk("mask0", 32'h0, q);
    repeat (256) @(posedge sys_clk);
    bus(1'b0, `OFS_CTRL_STATUS, 32'h0);
    chk("initEnd", 32'h4, q & 32'h6);
    chk("wrAllow", 32'h1, {31'h0, channelWrAllow});
  endtask
  task automatic tClr();
    bus(1'b1, `OFS_CLEAR_STATUS, 32'hFFFFFFFB);
    bus(1'b1, `OFS_IRQ_ENABLE, 32'h4);
    irqIs(1'b1);
    bus(1'b1, `OFS_CLEAR_STATUS, 32'h4);
    irqIs(1'b0);
    bus(1'b0, `OFS_CTRL_STATUS, 32'h0);
    chk("done", 32'h0, q & 32'h4);
    bus(1'b1, `OFS_IRQ_ENABLE, 32'hFFFFFFFF);
    bus(1'b0, `OFS_IRQ_MASK, 32'h0);
    chk("maskAll", 32'h1C, q);
    bus(1'b1, `OFS_IRQ_DISABLE, 32'h8);
    bus(1'b0, `OFS_IRQ_MASK, 32'h0);
    chk("maskDis", 32'h14, q);
    bus(1'b1, `OFS_IRQ_DISABLE, 32'h14);
    bus(1'b0, `OFS_IRQ_ENABLE, 32'h0);
    chk("woRead", 32'h0, q);
    bus(1'b0, 8'h00, 32'h0);
    chk("unmapped", 32'h0, q);
  endtask
  task automatic tEvents();
    for (int i = 0; i < 2; i++) begin
      eng.setLvl(5'h2 << i, 8'h00, 8'h00);
      irqIs(1'b0);
      bus(1'b1, `OFS_IRQ_ENABLE, 32'h8 << i);
      irqIs(1'b1);
      bus(1'b0, `OFS_CTRL_STATUS, 32'h0);
      chk("event", 32'h8 << i, q & 32'h18);
      bus(1'b1, `OFS_IRQ_DISABLE, 32'h8 << i);
      eng.setLvl(5'h00, 8'h00, 8'h00);
    end
  endtask
  task automatic tLevels();
    bus(1'b1, `OFS_IRQ_ENABLE, 32'h1C);
    eng.setLvl(5'h19, 8'h5A, 8'hC3);
    channelEnable <= 32'hF0F0F0F0;
    irqIs(1'b0);
    chk("active", 32'h0, channelActive);
    bus(1'b0, `OFS_CTRL_STATUS, 32'h0);
    chk("levels", 32'hC35A0061, q);
    eng.setLvl(5'h00, 8'h00, 8'hFF);
    irqIs(1'b0);
    chk("active", 32'hF0F0F0F0, channelActive);
    bus(1'b1, `OFS_IRQ_DISABLE, 32'h1C);
  endtask
  task automatic tChan();
    eng.pulse(32'h80000001);
    irqIs(1'b1);
    chk("pend", 32'h80000001, channelIrqPending);
    bus(1'b0, `OFS_CTRL_STATUS, 32'h0);
    chk("sum", 32'h80, q & 32'h80);
    bus(1'b1, `OFS_CHANNEL_IRQ_CLEAR, 32'h1);
    irqIs(1'b1);
    chk("clr0", 32'h80000000, channelIrqPending);
    bus(1'b1, `OFS_CHANNEL_IRQ_CLEAR, 32'h80000000);
    irqIs(1'b0);
    bus(1'b0, `OFS_CTRL_STATUS, 32'h0);
    chk("noSum", 32'h0, q & 32'h80);
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    tInit();
    tClr();
    tEvents();
    tLevels();
    tChan();
    wrapUp();
  end
endmodule
`default_nettype wire

//--- verilog/can_init_timer.sv
/*
  Initialization timer: holds busy after reset for a fixed cycle count,
  then pulses done once.
  Assumes a synchronous active-low reset on sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "can_status_cfg.svh"

module can_init_timer #(
  parameter int CYCLES = 256
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  output logic      busy,
  output logic      donePulse
);
  localparam int CW = $clog2(CYCLES + 1);

  typedef struct packed {
    can_status_pkg::init_state_t st;
    logic [CW-1:0]               cnt;
    logic                        done;
  } timer_state_t;

  timer_state_t state_q;
  timer_state_t state_d;

  initial begin
    if (CYCLES < 1) begin
      $error("can_init_timer: CYCLES must be at least 1");
    end
  end

  always_comb begin
    state_d = state_q;
    state_d.done = 1'b0;
    unique case (state_q.st)
      can_status_pkg::INIT_RUN: begin
        if (state_q.cnt == CW'(CYCLES - 1)) begin
          state_d.st = can_status_pkg::INIT_IDLE;
          state_d.done = 1'b1;
        end else begin
          state_d.cnt = state_q.cnt + CW'(1);
        end
      end
      can_status_pkg::INIT_IDLE: begin
        state_d.cnt = state_q.cnt;
      end
      default: begin
        state_d.st = can_status_pkg::INIT_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_q.st <= can_status_pkg::INIT_RUN;
      state_q.cnt <= '0;
      state_q.done <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign busy      = (state_q.st == can_status_pkg::INIT_RUN);
  assign donePulse = state_q.done;
endmodule
`default_nettype wire

//--- verilog/can_status_cfg.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  CAN status and interrupt block. Assumes inclusion by bare name.
*/
`ifndef CAN_STATUS_CFG_SVH
`define CAN_STATUS_CFG_SVH

`define OFS_CLEAR_STATUS      8'h6C
`define OFS_CTRL_STATUS       8'h70
`define OFS_IRQ_ENABLE        8'h74
`define OFS_IRQ_DISABLE       8'h78
`define OFS_IRQ_MASK          8'h7C
`define OFS_CHANNEL_IRQ_CLEAR 8'h80
`define OFS_EVENT_STATUS      8'h94
`define OFS_EVENT_CLEAR       8'h98
`define OFS_EVENT_ENABLE      8'h9C

`define BIT_ENABLED     0
`define BIT_INIT_PROG   1
`define BIT_INIT_DONE   2
`define BIT_ERR_PASSIVE 3
`define BIT_BUS_OFF     4
`define BIT_ABORT       5
`define BIT_OVERLOAD    6
`define BIT_CHAN_SUM    7
`define LSB_RX_ERR      16
`define LSB_TX_ERR      24

`define INIT_CYCLES_PER_CHANNEL 8
`define RESET_EVENT_ENABLE      3'h0
`define RESET_MASK              3'h0

`endif

//--- verilog/can_status_interrupt_regs.sv
/*
  Status and interrupt-control registers of a CAN controller, a classic
  Wishbone slave with 32-bit data. Assumes the protocol engine on sys_clk
  drives its state levels, error counters and per-channel interrupt pulses.
*/
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
`include "can_status_cfg.svh"

module can_status_interrupt_regs #(
  parameter int CHANNELS = 32
) (
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic                ctrlEnabled,
  input  wire logic                errPassive,
  input  wire logic                bus_off_flag,
  input  wire logic                abortReq,
  input  wire logic                overloadReq,
  input  wire logic [7:0]          rxErrCount,
  input  wire logic [7:0]          txErrCount,
  input  wire logic [CHANNELS-1:0] channelIrqSet,
  input  wire logic [CHANNELS-1:0] channelEnable,
  input  wire logic                channelWrReq,
  output logic                     channelWrAllow,
  output logic [CHANNELS-1:0]      channelActive,
  output logic [CHANNELS-1:0]      channelIrqPending,
  output logic                     initInProgress,
  output logic                     irq
);
  localparam int INIT_CYCLES = `INIT_CYCLES_PER_CHANNEL * CHANNELS;

  typedef struct packed {
    logic                ack;
    logic [31:0]         rdata;
    logic                initDone;
    logic                errPassiveFlag;
    logic                busOffFlag;
    logic                errPassivePrev;
    logic                busOffPrev;
    logic [2:0]          mask;
    logic [CHANNELS-1:0] chanPending;
    logic [2:0]          evStatus;
    logic [2:0]          evEnable;
  } regs_state_t;

  regs_state_t state_q;
  regs_state_t state_d;
  logic        initBusy;
  logic        initDonePulse;
  logic        wrStrobe;
  logic        rdStrobe;
  logic [31:0] wdata;
  logic [31:0] statusWord;
  logic [31:0] chanClearBits;
  logic [2:0]  evSet;
  logic [2:0]  flagMask;
  logic [CHANNELS-1:0] chanNext;

  initial begin
    if (CHANNELS < 1 || CHANNELS > 32) begin
      $error("can_status_interrupt_regs: CHANNELS must be 1 to 32");
    end
  end

  can_init_timer #(
    .CYCLES (INIT_CYCLES)
  ) u_init_timer (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .busy      (initBusy),
    .donePulse (initDonePulse)
  );

  // Byte lanes not selected read as zero in the write data.
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wdata[b*8 +: 8] = wb_sel_i[b] ? wb_dat_i[b*8 +: 8] : 8'h00;
    end
  end

  // A request is answered one cycle after it is seen; the ack cycle masks
  // the still-held request so that each access acts exactly once.
  assign wrStrobe = wb_cyc_i && wb_stb_i && wb_we_i && !state_q.ack;
  assign rdStrobe = wb_cyc_i && wb_stb_i && !wb_we_i && !state_q.ack;

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[`BIT_ENABLED]     = ctrlEnabled;
    statusWord[`BIT_INIT_PROG]   = initBusy;
    statusWord[`BIT_INIT_DONE]   = state_q.initDone;
    statusWord[`BIT_ERR_PASSIVE] = state_q.errPassiveFlag;
    statusWord[`BIT_BUS_OFF]     = state_q.busOffFlag;
    statusWord[`BIT_ABORT]       = abortReq;
    statusWord[`BIT_OVERLOAD]    = overloadReq;
    statusWord[`BIT_CHAN_SUM]    = |state_q.chanPending;
    statusWord[`LSB_RX_ERR +: 8] = rxErrCount;
    statusWord[`LSB_TX_ERR +: 8] = txErrCount;
  end

  assign chanClearBits = (wrStrobe && wb_adr_i == `OFS_CHANNEL_IRQ_CLEAR) ? wdata : 32'h0;

  always_comb begin
    state_d = state_q;
    state_d.ack = wb_cyc_i && wb_stb_i && !state_q.ack;
    state_d.errPassivePrev = errPassive;
    state_d.busOffPrev = bus_off_flag;
    state_d.chanPending = chanNext;
    if (wrStrobe && wb_adr_i == `OFS_CLEAR_STATUS && wdata[`BIT_INIT_DONE]) begin
      state_d.initDone = 1'b0;
    end
    if (wrStrobe && wb_adr_i == `OFS_IRQ_ENABLE) begin
      state_d.mask = state_q.mask | wdata[`BIT_BUS_OFF:`BIT_INIT_DONE];
    end
    if (wrStrobe && wb_adr_i == `OFS_IRQ_DISABLE) begin
      state_d.mask = state_q.mask & ~wdata[`BIT_BUS_OFF:`BIT_INIT_DONE];
    end
    if (wrStrobe && wb_adr_i == `OFS_EVENT_ENABLE) begin
      state_d.evEnable = wdata[2:0];
    end
    if (wrStrobe && wb_adr_i == `OFS_EVENT_CLEAR) begin
      state_d.evStatus = state_q.evStatus & ~wdata[2:0];
    end
    // Hardware sets win over software clears in the same cycle.
    if (initDonePulse) begin
      state_d.initDone = 1'b1;
    end
    if (errPassive && !state_q.errPassivePrev) begin
      state_d.errPassiveFlag = 1'b1;
    end
    if (bus_off_flag && !state_q.busOffPrev) begin
      state_d.busOffFlag = 1'b1;
    end
    state_d.evStatus = state_d.evStatus | evSet;
    state_d.rdata = 32'h0000_0000;
    if (rdStrobe) begin
      unique case (wb_adr_i)
        `OFS_CTRL_STATUS: state_d.rdata = statusWord;
        `OFS_IRQ_MASK: state_d.rdata = {27'h0, state_q.mask, 2'h0};
        `OFS_EVENT_STATUS: state_d.rdata = {29'h0, state_q.evStatus};
        `OFS_EVENT_ENABLE: state_d.rdata = {29'h0, state_q.evEnable};
        default: state_d.rdata = 32'h0000_0000;
      endcase
      if (wb_adr_i == `OFS_CTRL_STATUS) begin
        // Reading status consumes the transition flags of the engine events.
        state_d.errPassiveFlag = errPassive && !state_q.errPassivePrev;
        state_d.busOffFlag = bus_off_flag && !state_q.busOffPrev;
      end
    end
  end

  // Per-channel pending flags: set beats clear.
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      assign chanNext[ch] = channelIrqSet[ch]
                            || (state_q.chanPending[ch] && !chanClearBits[ch]);
      assign channelActive[ch] = channelEnable[ch] && !abortReq;
    end
  endgenerate

  // Event status only records the three documented interrupt sources.
  assign evSet = {bus_off_flag && !state_q.busOffPrev,
                  errPassive && !state_q.errPassivePrev,
                  initDonePulse};

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_q.ack <= 1'b0;
      state_q.rdata <= 32'h0000_0000;
      state_q.initDone <= 1'b0;
      state_q.errPassiveFlag <= 1'b0;
      state_q.busOffFlag <= 1'b0;
      state_q.errPassivePrev <= 1'b0;
      state_q.busOffPrev <= 1'b0;
      state_q.mask <= `RESET_MASK;
      state_q.chanPending <= '0;
      state_q.evStatus <= 3'h0;
      state_q.evEnable <= `RESET_EVENT_ENABLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign flagMask = {state_q.busOffFlag, state_q.errPassiveFlag, state_q.initDone};
  assign irq = |(flagMask & state_q.mask) || |state_q.chanPending
               || |(state_q.evStatus & state_q.evEnable);
  assign channelIrqPending = state_q.chanPending;
  assign wb_ack_o = state_q.ack;
  assign wb_dat_o = state_q.rdata;
  assign initInProgress = initBusy;
  assign channelWrAllow = channelWrReq && !initBusy;
  // The abort only gates channel enables; the engine finishes its frame.
endmodule
`default_nettype wire

//--- verilog/can_status_pkg.sv
/*
  Types of the CAN status and interrupt block.
  Assumes nothing of its surroundings.
*/
package can_status_pkg;
  typedef enum logic [1:0] {
    INIT_RUN  = 2'b01,
    INIT_IDLE = 2'b10
  } init_state_t;
endpackage
